// ===== sp_consts.svh
// Offsets, field positions, defaults and timing for the serial port setup block.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH
`define SP_OFS_CFG_STG  5'h00
`define SP_OFS_DLY_STG  5'h04
`define SP_OFS_CFG_ACT  5'h08
`define SP_OFS_DLY_ACT  5'h0C
`define SP_OFS_STATUS   5'h10
`define SP_OFS_TXDATA   5'h14
`define SP_OFS_RXDATA   5'h18
`define SP_F_PROTO      0
`define SP_F_NODE       8
`define SP_F_BAUD       16
`define SP_F_LEN8       20
`define SP_F_STOP2      21
`define SP_F_PAR        24
`define SP_F_STICKY     4
`define SP_CFG_RST      32'h01230100
`define SP_DEF_NODE     7'h01
`define SP_DEF_BAUD     3'h3
`define SP_DEF_PAR      2'h1
`define SP_DEF_DLY      7'h14
`define SP_NODE_MAX     7'h63
`define SP_BAUD_MAX     3'h6
`define SP_DLY_MAX      7'h63
`define SP_BAUD_0       1200
`define SP_BAUD_1       2400
`define SP_BAUD_2       4800
`define SP_BAUD_3       9600
`define SP_BAUD_4       19200
`define SP_BAUD_5       38400
`define SP_BAUD_6       57600
`define SP_MS_PER_S     1000
`define SP_GAP_BITS     5'h14
`endif

// ===== sp_pkg.sv
// State types for the serial port setup block.
// Assumes nothing beyond the consts header holding the numbers.
package sp_pkg;
    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } sp_rx_st_t;
    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } sp_tx_st_t;
    typedef enum logic [3:0] {
        FR_ADDR = 4'h1,
        FR_TAKE = 4'h2,
        FR_DROP = 4'h4,
        FR_WAIT = 4'h8
    } sp_frm_st_t;
endpackage

// ===== sp_char_tx.sv
// Character serializer: start, data LSB first, optional parity, stop bits.
// Assumes framing inputs and divisor stay stable while a character is sent.
`timescale 1ns/10ps
`include "sp_consts.svh"
module sp_char_tx import sp_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [7:0]  data,
    input  wire logic        len8,
    input  wire logic        par_en,
    input  wire logic        par_odd,
    input  wire logic        stop2,
    input  wire logic [23:0] div,
    output logic             txd,
    output logic             busy
);
    sp_tx_st_t   st_ff,  nxt_st;
    logic [23:0] cnt_ff, nxt_cnt;
    logic [2:0]  bit_ff, nxt_bit;
    logic [7:0]  sh_ff,  nxt_sh;
    logic        par_ff, nxt_par;
    logic        txd_ff, nxt_txd;
    logic        tick;
    logic [2:0]  last;

    assign tick = (cnt_ff == 24'h0);
    assign last = len8 ? 3'h7 : 3'h6;
    assign txd  = txd_ff;
    assign busy = (st_ff != TX_IDLE);

    always_comb begin
        nxt_st  = st_ff;
        nxt_bit = bit_ff;
        nxt_sh  = sh_ff;
        nxt_par = par_ff;
        nxt_txd = txd_ff;
        nxt_cnt = tick ? div - 24'h1 : cnt_ff - 24'h1;
        case (st_ff)
            TX_IDLE: begin
                nxt_cnt = cnt_ff;
                if (start) begin
                    nxt_sh  = data;
                    nxt_par = 1'b0;
                    nxt_txd = 1'b0;
                    nxt_cnt = div - 24'h1;
                    nxt_st  = TX_START;
                end
            end
            TX_START, TX_DATA: begin
                if (tick) begin
                    if (st_ff == TX_DATA && bit_ff == last) begin
                        nxt_bit = 3'h0;
                        if (par_en) begin
                            nxt_txd = par_ff ^ par_odd;
                            nxt_st  = TX_PAR;
                        end else begin
                            nxt_txd = 1'b1;
                            nxt_st  = TX_STOP;
                        end
                    end else begin
                        nxt_txd = sh_ff[0];
                        nxt_par = par_ff ^ sh_ff[0];
                        nxt_sh  = {1'b0, sh_ff[7:1]};
                        nxt_bit = (st_ff == TX_START) ? 3'h0 : bit_ff + 3'h1;
                        nxt_st  = TX_DATA;
                    end
                end
            end
            TX_PAR: begin
                if (tick) begin
                    nxt_txd = 1'b1;
                    nxt_st  = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tick) begin
                    if (stop2 && bit_ff == 3'h0) begin
                        nxt_bit = 3'h1;
                    end else begin
                        nxt_st = TX_IDLE;
                    end
                end
            end
            default: begin
                nxt_st  = TX_IDLE;
                nxt_txd = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff  <= TX_IDLE;
            cnt_ff <= 24'h0;
            bit_ff <= 3'h0;
            sh_ff  <= 8'h0;
            par_ff <= 1'b0;
            txd_ff <= 1'b1;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sh_ff  <= nxt_sh;
            par_ff <= nxt_par;
            txd_ff <= nxt_txd;
        end
    end

    property p_start_low;
        @(posedge sys_clk) disable iff (sys_rst) (st_ff == TX_START) |-> !txd_ff;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
    property p_stop_high;
        @(posedge sys_clk) disable iff (sys_rst) (st_ff == TX_STOP) |-> txd_ff;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
    c_two_stop: cover property (@(posedge sys_clk) st_ff == TX_STOP && bit_ff == 3'h1);
endmodule

// ===== sp_serial_port_setup.sv
// Serial port setup: power-on latched settings, Avalon-MM registers, RX, TX.
// Assumes rxd is synchronous to sys_clk and nv_cfg_word/nv_delay_ms hold the
// stored settings while sys_rst is released.
`timescale 1ns/10ps
`include "sp_consts.svh"
module sp_serial_port_setup import sp_pkg::*; #(
    parameter int CLK_HZ    = 125000000,
    parameter int MS_CYCLES = CLK_HZ / `SP_MS_PER_S
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] nv_cfg_word,
    input  wire logic [6:0]  nv_delay_ms,
    output logic [31:0]      store_cfg_word,
    output logic [6:0]       store_delay_ms,
    input  wire logic        rxd,
    output logic             txd
);
    // Out-of-range stored values fall back to defaults
    function automatic logic [31:0] sp_clean(input logic [31:0] w);
        logic [31:0] r;
        r = `SP_CFG_RST;
        r[`SP_F_PROTO] = w[`SP_F_PROTO];
        if (w[`SP_F_NODE +: 7] <= `SP_NODE_MAX) r[`SP_F_NODE +: 7] = w[`SP_F_NODE +: 7];
        if (w[`SP_F_BAUD +: 3] <= `SP_BAUD_MAX) r[`SP_F_BAUD +: 3] = w[`SP_F_BAUD +: 3];
        r[`SP_F_LEN8]  = w[`SP_F_LEN8];
        r[`SP_F_STOP2] = w[`SP_F_STOP2];
        if (w[`SP_F_PAR +: 2] != 2'h3) r[`SP_F_PAR +: 2] = w[`SP_F_PAR +: 2];
        return r;
    endfunction

    function automatic logic [23:0] sp_div(input logic [2:0] c);
        int r;
        case (c)
            3'h0:    r = CLK_HZ / `SP_BAUD_0;
            3'h1:    r = CLK_HZ / `SP_BAUD_1;
            3'h2:    r = CLK_HZ / `SP_BAUD_2;
            3'h4:    r = CLK_HZ / `SP_BAUD_4;
            3'h5:    r = CLK_HZ / `SP_BAUD_5;
            3'h6:    r = CLK_HZ / `SP_BAUD_6;
            default: r = CLK_HZ / `SP_BAUD_3;
        endcase
        return 24'(r);
    endfunction

    logic        cap_done_ff, nxt_cap_done;
    logic [31:0] cfg_act_ff,  nxt_cfg_act;
    logic [6:0]  dly_act_ff,  nxt_dly_act;
    logic        proto_mb, eff_len8, eff_stop2, par_en, par_odd;
    logic [6:0]  node_act;
    logic [23:0] div;

    always_comb begin
        nxt_cap_done = 1'b1;
        nxt_cfg_act  = cfg_act_ff;
        nxt_dly_act  = dly_act_ff;
        if (!cap_done_ff) begin
            nxt_cfg_act = sp_clean(nv_cfg_word);
            nxt_dly_act = (nv_delay_ms <= `SP_DLY_MAX) ? nv_delay_ms : `SP_DEF_DLY;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_done_ff <= 1'b0;
            cfg_act_ff  <= `SP_CFG_RST;
            dly_act_ff  <= `SP_DEF_DLY;
        end else begin
            cap_done_ff <= nxt_cap_done;
            cfg_act_ff  <= nxt_cfg_act;
            dly_act_ff  <= nxt_dly_act;
        end
    end

    assign proto_mb  = cfg_act_ff[`SP_F_PROTO];
    assign eff_len8  = proto_mb | cfg_act_ff[`SP_F_LEN8];
    assign eff_stop2 = !proto_mb & cfg_act_ff[`SP_F_STOP2];
    assign par_en    = (cfg_act_ff[`SP_F_PAR +: 2] != 2'h0);
    assign par_odd   = (cfg_act_ff[`SP_F_PAR +: 2] == 2'h2);
    assign node_act  = cfg_act_ff[`SP_F_NODE +: 7];
    assign div       = sp_div(cfg_act_ff[`SP_F_BAUD +: 3]);

    // Receiver: mid-bit sampling, idle gap marks end of frame
    sp_rx_st_t   rx_st_ff,  nxt_rx_st;
    logic [23:0] rx_cnt_ff, nxt_rx_cnt;
    logic [2:0]  rx_bit_ff, nxt_rx_bit;
    logic [7:0]  rx_sh_ff,  nxt_rx_sh;
    logic        rx_par_ff, nxt_rx_par;
    logic        rx_err_ff, nxt_rx_err;
    logic [4:0]  rx_gap_ff, nxt_rx_gap;
    logic        rx_tick, ch_done, ch_bad, fr_end;
    logic [7:0]  ch_data;

    assign rx_tick = (rx_cnt_ff == 24'h0);
    assign ch_data = eff_len8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};

    always_comb begin
        nxt_rx_st  = rx_st_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_sh  = rx_sh_ff;
        nxt_rx_par = rx_par_ff;
        nxt_rx_err = rx_err_ff;
        nxt_rx_gap = rx_gap_ff;
        nxt_rx_cnt = rx_tick ? div - 24'h1 : rx_cnt_ff - 24'h1;
        ch_done    = 1'b0;
        ch_bad     = 1'b0;
        fr_end     = 1'b0;
        case (rx_st_ff)
            RX_IDLE: begin
                if (!rxd) begin
                    nxt_rx_cnt = {1'b0, div[23:1]};
                    nxt_rx_gap = 5'h0;
                    nxt_rx_st  = RX_START;
                end else if (rx_tick && rx_gap_ff != `SP_GAP_BITS) begin
                    nxt_rx_gap = rx_gap_ff + 5'h1;
                    fr_end     = (rx_gap_ff == `SP_GAP_BITS - 5'h1);
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    nxt_rx_bit = 3'h0;
                    nxt_rx_par = 1'b0;
                    nxt_rx_err = 1'b0;
                    nxt_rx_st  = rxd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    nxt_rx_sh  = {rxd, rx_sh_ff[7:1]};
                    nxt_rx_par = rx_par_ff ^ rxd;
                    nxt_rx_bit = rx_bit_ff + 3'h1;
                    if (rx_bit_ff == (eff_len8 ? 3'h7 : 3'h6)) begin
                        nxt_rx_st = par_en ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_tick) begin
                    nxt_rx_err = ((rx_par_ff ^ rxd) != par_odd);
                    nxt_rx_st  = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_tick) begin
                    ch_done   = 1'b1;
                    ch_bad    = rx_err_ff | !rxd;
                    nxt_rx_st = RX_IDLE;
                end
            end
            default: nxt_rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_ff  <= RX_IDLE;
            rx_cnt_ff <= 24'h0;
            rx_bit_ff <= 3'h0;
            rx_sh_ff  <= 8'h0;
            rx_par_ff <= 1'b0;
            rx_err_ff <= 1'b0;
            rx_gap_ff <= `SP_GAP_BITS;
        end else begin
            rx_st_ff  <= nxt_rx_st;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_bit_ff <= nxt_rx_bit;
            rx_sh_ff  <= nxt_rx_sh;
            rx_par_ff <= nxt_rx_par;
            rx_err_ff <= nxt_rx_err;
            rx_gap_ff <= nxt_rx_gap;
        end
    end

    // Frame filter and response delay
    sp_frm_st_t  frm_ff,      nxt_frm;
    logic        allow_ff,    nxt_allow;
    logic [6:0]  dly_cnt_ff,  nxt_dly_cnt;
    logic [23:0] ms_cnt_ff,   nxt_ms_cnt;
    logic [7:0]  rx_data_ff,  nxt_rx_data;
    logic        rx_vld_ff,   nxt_rx_vld;
    logic        push, pop, ovr_evt, tx_start;

    always_comb begin
        nxt_frm     = frm_ff;
        nxt_allow   = allow_ff;
        nxt_dly_cnt = dly_cnt_ff;
        nxt_ms_cnt  = ms_cnt_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_vld  = rx_vld_ff & !pop;
        push        = 1'b0;
        if (frm_ff == FR_WAIT) begin
            if (dly_cnt_ff == 7'h0) begin
                nxt_allow = 1'b1;
                nxt_frm   = FR_ADDR;
            end else if (ms_cnt_ff == 24'h0) begin
                nxt_ms_cnt  = 24'(MS_CYCLES - 1);
                nxt_dly_cnt = dly_cnt_ff - 7'h1;
            end else begin
                nxt_ms_cnt = ms_cnt_ff - 24'h1;
            end
        end
        case (frm_ff)
            FR_ADDR, FR_WAIT: begin
                if (ch_done) begin
                    nxt_allow = 1'b0;
                    nxt_frm   = (!ch_bad && ch_data == {1'b0, node_act}) ? FR_TAKE : FR_DROP;
                end
            end
            FR_TAKE: begin
                push = ch_done & !ch_bad;
                if (fr_end) begin
                    nxt_dly_cnt = dly_act_ff;
                    nxt_ms_cnt  = 24'(MS_CYCLES - 1);
                    nxt_frm     = FR_WAIT;
                end
            end
            FR_DROP: begin
                if (fr_end) nxt_frm = FR_ADDR;
            end
            default: nxt_frm = FR_ADDR;
        endcase
        if (push) begin
            nxt_rx_data = ch_data;
            nxt_rx_vld  = 1'b1;
        end
        ovr_evt = push & rx_vld_ff & !pop;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frm_ff     <= FR_ADDR;
            allow_ff   <= 1'b0;
            dly_cnt_ff <= 7'h0;
            ms_cnt_ff  <= 24'h0;
            rx_data_ff <= 8'h0;
            rx_vld_ff  <= 1'b0;
        end else begin
            frm_ff     <= nxt_frm;
            allow_ff   <= nxt_allow;
            dly_cnt_ff <= nxt_dly_cnt;
            ms_cnt_ff  <= nxt_ms_cnt;
            rx_data_ff <= nxt_rx_data;
            rx_vld_ff  <= nxt_rx_vld;
        end
    end

    // Avalon slave: one wait cycle, then the access completes
    logic        wait_ff,    nxt_wait;
    logic [31:0] rdata_ff,   nxt_rdata;
    logic [31:0] cfg_stg_ff, nxt_cfg_stg;
    logic [6:0]  dly_stg_ff, nxt_dly_stg;
    logic [2:0]  sticky_ff,  nxt_sticky;
    logic [7:0]  hold_ff,    nxt_hold;
    logic        full_ff,    nxt_full;
    logic        acc, tx_busy;
    logic [31:0] wmask;

    assign acc      = (avs_read | avs_write) & !wait_ff;
    assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign pop      = acc & avs_read & (avs_address == `SP_OFS_RXDATA);
    assign tx_start = full_ff & !tx_busy & allow_ff;

    always_comb begin
        nxt_wait    = 1'b1;
        nxt_rdata   = rdata_ff;
        nxt_cfg_stg = cfg_stg_ff;
        nxt_dly_stg = dly_stg_ff;
        nxt_hold    = hold_ff;
        nxt_full    = full_ff & !tx_start;
        nxt_sticky  = sticky_ff;
        if ((avs_read | avs_write) && wait_ff) begin
            nxt_wait = 1'b0;
            case (avs_address)
                `SP_OFS_CFG_STG: nxt_rdata = cfg_stg_ff;
                `SP_OFS_DLY_STG: nxt_rdata = {25'h0, dly_stg_ff};
                `SP_OFS_CFG_ACT: nxt_rdata = cfg_act_ff;
                `SP_OFS_DLY_ACT: nxt_rdata = {25'h0, dly_act_ff};
                `SP_OFS_STATUS:  nxt_rdata = {25'h0, sticky_ff, allow_ff, rx_vld_ff,
                                              tx_busy, !full_ff};
                `SP_OFS_RXDATA:  nxt_rdata = {24'h0, rx_data_ff};
                default:         nxt_rdata = 32'h0;
            endcase
        end
        if (acc && avs_write) begin
            case (avs_address)
                `SP_OFS_CFG_STG: nxt_cfg_stg = (cfg_stg_ff & ~wmask) | (avs_writedata & wmask);
                `SP_OFS_DLY_STG: if (avs_byteenable[0]) nxt_dly_stg = avs_writedata[6:0];
                `SP_OFS_STATUS:  if (avs_byteenable[0])
                                     nxt_sticky = sticky_ff & ~avs_writedata[`SP_F_STICKY +: 3];
                `SP_OFS_TXDATA:  if (!full_ff && avs_byteenable[0]) begin
                                     nxt_hold = avs_writedata[7:0];
                                     nxt_full = 1'b1;
                                 end
                default:         nxt_cfg_stg = cfg_stg_ff;
            endcase
        end
        // Events win over a clear in the same cycle
        nxt_sticky = nxt_sticky | {acc & avs_write & (avs_address == `SP_OFS_TXDATA) & full_ff,
                                   ch_done & ch_bad, ovr_evt};
        if (!cap_done_ff) begin
            nxt_cfg_stg = sp_clean(nv_cfg_word);
            nxt_dly_stg = (nv_delay_ms <= `SP_DLY_MAX) ? nv_delay_ms : `SP_DEF_DLY;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_ff    <= 1'b1;
            rdata_ff   <= 32'h0;
            cfg_stg_ff <= `SP_CFG_RST;
            dly_stg_ff <= `SP_DEF_DLY;
            sticky_ff  <= 3'h0;
            hold_ff    <= 8'h0;
            full_ff    <= 1'b0;
        end else begin
            wait_ff    <= nxt_wait;
            rdata_ff   <= nxt_rdata;
            cfg_stg_ff <= nxt_cfg_stg;
            dly_stg_ff <= nxt_dly_stg;
            sticky_ff  <= nxt_sticky;
            hold_ff    <= nxt_hold;
            full_ff    <= nxt_full;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign store_cfg_word  = cfg_stg_ff;
    assign store_delay_ms  = dly_stg_ff;

    sp_char_tx u_tx (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (tx_start),
        .data    (hold_ff),
        .len8    (eff_len8),
        .par_en  (par_en),
        .par_odd (par_odd),
        .stop2   (eff_stop2),
        .div     (div),
        .txd     (txd),
        .busy    (tx_busy)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_cfg_frozen;
        cap_done_ff |=> $stable(cfg_act_ff) && $stable(dly_act_ff);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("active settings moved");
    property p_cfg_capture;
        !cap_done_ff |=> cfg_act_ff == sp_clean($past(nv_cfg_word));
    endproperty
    a_cfg_capture: assert property (p_cfg_capture) else $error("bad capture");
    property p_mb_frame;
        proto_mb |-> eff_len8 && !eff_stop2;
    endproperty
    a_mb_frame: assert property (p_mb_frame) else $error("modbus framing wrong");
    property p_ranges;
        node_act <= `SP_NODE_MAX && cfg_act_ff[`SP_F_BAUD +: 3] <= `SP_BAUD_MAX;
    endproperty
    a_ranges: assert property (p_ranges) else $error("node or rate out of range");
    property p_par_code;
        cfg_act_ff[`SP_F_PAR +: 2] != 2'h3;
    endproperty
    a_par_code: assert property (p_par_code) else $error("parity code invalid");
    property p_tx_gate;
        tx_start |-> allow_ff && frm_ff != FR_TAKE;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("send before delay");
    property p_allow_rise;
        $rose(allow_ff) |-> $past(frm_ff) == FR_WAIT && $past(dly_cnt_ff) == 7'h0;
    endproperty
    a_allow_rise: assert property (p_allow_rise) else $error("delay cut short");
    property p_push_take;
        push |-> frm_ff == FR_TAKE;
    endproperty
    a_push_take: assert property (p_push_take) else $error("foreign frame kept");
    c_drop:  cover property (ch_done && !ch_bad && frm_ff == FR_ADDR && ch_data != {1'b0, node_act});
    c_push:  cover property (push);
    c_allow: cover property ($rose(allow_ff));
    c_send:  cover property (tx_start);
endmodule

// ===== sp_host_model.sv
// Remote host on the serial line: 7E2 characters, or 8O1 while mb is set.
// Assumes one bit lasts BT cycles of sys_clk and txd idles high.
`timescale 1ns/10ps
module sp_host_model #(
    parameter int BT = 125
) (
    input  wire logic sys_clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] rx_byte = 8'h00;
    logic [9:0] s;
    logic       rx_err = 1'b0;
    logic       mb = 1'b0;
    int         rx_cnt = 0;
    initial rxd = 1'b1;
    // Start low, data LSB first, parity, high stops
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = mb ? {1'b1, ~^b, b, 1'b0} : {2'b11, ^b[6:0], b[6:0], 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BT) @(posedge sys_clk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (BT / 2) @(posedge sys_clk);
        for (int i = 0; i < (mb ? 10 : 9); i++) begin
            repeat (BT) @(posedge sys_clk);
            s[i] = txd;
        end
        rx_byte = mb ? s[7:0] : {1'b0, s[6:0]};
        rx_err = mb ? (~^s[8:0] | ~s[9]) : (^s[7:0] | ~s[8]);
        rx_cnt++;
        // Only to the end of the first stop, so a 1-stop next start is not missed
        repeat (BT / 2) @(posedge sys_clk);
    end
endmodule

// ===== sp_serial_port_setup_tb.sv
// Testbench: registers over Avalon-MM, frames from the host model.
// Assumes the shortened clock rate so one bit lasts 125 cycles.
`timescale 1ns/10ps
`include "sp_consts.svh"
module sp_serial_port_setup_tb;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] nv_cfg_word = 32'h01237000;
    logic [6:0]  nv_delay_ms = 7'h02;
    logic [31:0] avs_readdata, store_cfg_word, d;
    logic        avs_waitrequest, rxd, txd;
    logic [6:0]  store_delay_ms;
    int          n_fail = 0;
    int          cmp_count = 0;
    always #4 sys_clk = ~sys_clk;
    sp_serial_port_setup #(.CLK_HZ(1200000), .MS_CYCLES(50)) uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nv_cfg_word(nv_cfg_word),
        .nv_delay_ms(nv_delay_ms), .store_cfg_word(store_cfg_word),
        .store_delay_ms(store_delay_ms), .rxd(rxd), .txd(txd));
    sp_host_model #(.BT(125)) host (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle edge first so a strobe is never reassigned in one step
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`SP_OFS_CFG_ACT);
        chk(d, `SP_CFG_RST);
        rd(`SP_OFS_DLY_ACT);
        chk(d, 32'h2);
        wr(`SP_OFS_CFG_STG, 32'h00100001);
        rd(`SP_OFS_CFG_STG);
        chk(d, 32'h00100001);
        chk(store_cfg_word, 32'h00100001);
        rd(`SP_OFS_CFG_ACT);
        chk(d, `SP_CFG_RST);
        rd(5'h1C);
        chk(d, 32'h0);
        // Held byte must wait for a matching frame plus delay
        wr(`SP_OFS_TXDATA, 32'h2A);
        host.send(8'h01);
        host.send(8'h35);
        chk(host.rx_cnt, 0);
        repeat (5000) @(posedge sys_clk);
        chk(host.rx_cnt, 1);
        chk(host.rx_byte, 32'h2A);
        chk(host.rx_err, 0);
        rd(`SP_OFS_RXDATA);
        chk(d, 32'h35);
        host.send(8'h02);
        wr(`SP_OFS_TXDATA, 32'h4C);
        host.send(8'h11);
        repeat (5000) @(posedge sys_clk);
        chk(host.rx_cnt, 1);
        // Second write while the byte still waits is dropped and flagged
        wr(`SP_OFS_TXDATA, 32'h77);
        rd(`SP_OFS_STATUS);
        chk(d, 32'h40);
        wr(`SP_OFS_STATUS, 32'h40);
        rd(`SP_OFS_STATUS);
        chk(d, 32'h0);
        avs_byteenable <= 4'h1;
        wr(`SP_OFS_CFG_STG, 32'hFFFFFF55);
        avs_byteenable <= 4'hF;
        rd(`SP_OFS_CFG_STG);
        chk(d, 32'h00100055);
        wr(`SP_OFS_DLY_STG, 32'h33);
        rd(`SP_OFS_DLY_STG);
        chk(d, 32'h33);
        chk({25'h0, store_delay_ms}, 32'h33);
        // Power-up again with Modbus, node 99, bad rate code, odd parity, delay 100
        nv_cfg_word <= 32'h02276311;
        nv_delay_ms <= 7'h64;
        host.mb = 1'b1;
        sys_rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`SP_OFS_CFG_ACT);
        chk(d, 32'h02236301);
        rd(`SP_OFS_DLY_ACT);
        chk(d, 32'h14);
        rd(`SP_OFS_STATUS);
        chk(d, 32'h1);
        chk(store_cfg_word, 32'h02236301);
        chk({25'h0, store_delay_ms}, 32'h14);
        wr(`SP_OFS_TXDATA, 32'hC3);
        host.send(8'h63);
        host.send(8'hA5);
        // 20 ms of 50 cycles each are over here, but the reply is still on the line
        repeat (4000) @(posedge sys_clk);
        chk(host.rx_cnt, 1);
        repeat (1500) @(posedge sys_clk);
        chk(host.rx_cnt, 2);
        chk(host.rx_byte, 32'hC3);
        chk(host.rx_err, 0);
        rd(`SP_OFS_RXDATA);
        chk(d, 32'hA5);
        final_report();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
endmodule
